// ===== rtl/rtcu_regs.svh
// Register offsets, field positions, codes and timing for the clock command unit
`ifndef RTCU_REGS_SVH
`define RTCU_REGS_SVH
`define RTCU_OFS_CMD 8'h00
`define RTCU_OFS_REG0 8'h04
`define RTCU_OFS_TIME 8'h08
`define RTCU_OFS_ALARM 8'h0c
`define RTCU_OFS_CONFIG 8'h10
`define RTCU_OFS_STATUS 8'h14
`define RTCU_OFS_IRQ_MASK 8'h18
`define RTCU_OPCODE 8'hdc
`define RTCU_ACT_INIT 4'h0
`define RTCU_ACT_START 4'h1
`define RTCU_ACT_STOP 4'h2
`define RTCU_ACT_MASK 4'h3
`define RTCU_ACT_WR_TIME 4'h4
`define RTCU_ACT_WR_ALARM 4'h5
`define RTCU_ACT_RD_TIME 4'h6
`define RTCU_ACT_RD_ALARM 4'h7
`define RTCU_ACT_COUNT_TO_TEXT 4'h8
`define RTCU_ACT_TEXT_TO_COUNT 4'h9
`define RTCU_ACT_COUNT_TO_FIELDS 4'ha
`define RTCU_ACT_FIELDS_TO_COUNT 4'hb
`define RTCU_OPT_PIN_EN 3
`define RTCU_OPT_SQUARE 2
`define RTCU_OPT_CAL 1
`define RTCU_OPT_ALARM_EN 0
`define RTCU_MASK_MAX 4'h9
`define RTCU_ST_ALARM 0
`define RTCU_ST_REJECT 1
`define RTCU_ST_CONVERT 2
`define RTCU_ST_W 3
`define RTCU_HALF_SEC_MS 500
`define RTCU_CLK_KHZ 125000
`define RTCU_CAL_W 8
`endif

// ===== rtl/rtcu_pkg.sv
// Types shared by the clock command unit
package rtcu_pkg;
  typedef struct packed {
    logic running;
    logic pin_en;
    logic square;
    logic cal_en;
    logic alarm_en;
    logic [3:0] mask;
    logic [7:0] cal;
    logic [3:0] last_action;
  } rtcu_cfg_type;
  typedef struct packed {
    rtcu_cfg_type cfg;
    logic [31:0] reg0;
    logic [31:0] now;
    logic [31:0] alarm;
    logic [31:0] next_alarm;
    logic [31:0] presc;
    logic half;
    logic [2:0] status;
    logic [2:0] irq_mask;
    logic pin;
    logic pin_oe;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rtcu_state_type;
endpackage

// ===== rtl/rtcu_top.sv
// Real-time clock command unit: command decode, timekeeping, alarm and APB registers
// What this block does
// - A command is the opcode byte 0xdc followed by one action byte, and only that opcode reaches the clock logic.
// - Action nibble 0 configures the clock, 1 starts it, 2 stops it and 3 loads the alarm mask.
// - Action 4 sets the time, 5 sets the alarm, 6 returns the time and 7 returns the alarm time.
// - Actions 8 to 0xb are the four format conversions, handed on as a conversion request.
// - Configure with option bit 0x08 enables the clock event pin, otherwise the pin stays disabled.
// - Configure with 0x04 clear toggles the pin on each alarm, with it set the pin carries a 1 Hz square.
// - Configure with 0x02 loads calibration from the low 8 bits of register 0, otherwise none applies.
// - Alarms come from the alarm time combined with the mask, set the event flag and may drive the pin.
// - The mask nibble picks the repeat period, 0 each half second up to 9 each year.
// - Time is a 32-bit count of seconds from the start of 2000-01-01.
`timescale 1ns/1ps
`default_nettype none
`include "rtcu_regs.svh"
module rtcu_top #(
  parameter int ADDR_W = 8,
  parameter int HALF_CYCLES = `RTCU_HALF_SEC_MS * `RTCU_CLK_KHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic clock_event_pin,
  output logic clock_event_pin_oe
);
  // Calibration may take up to 128 cycles off a half second, so the count must stay positive
  if (HALF_CYCLES <= 256 || ADDR_W < 5 || ADDR_W > 32) begin : g_bad_params
    $error("rtcu_top: unsupported HALF_CYCLES or ADDR_W");
  end

  rtcu_pkg::rtcu_state_type st;
  rtcu_pkg::rtcu_state_type next_st;

  localparam logic [31:0] HALF_LAST = 32'(HALF_CYCLES - 1);

  // Repeat period in seconds; month and year use fixed 30 and 365 day lengths
  function automatic logic [31:0] period_of(input logic [3:0] m);
    case (m)
      4'h2: period_of = 32'h0000000a;
      4'h3: period_of = 32'h0000003c;
      4'h4: period_of = 32'h00000258;
      4'h5: period_of = 32'h00000e10;
      4'h6: period_of = 32'h00015180;
      4'h7: period_of = 32'h00093a80;
      4'h8: period_of = 32'h00278d00;
      4'h9: period_of = 32'h01e13380;
      default: period_of = 32'h00000001;
    endcase
  endfunction

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    is_reg = (a == ADDR_W'(ofs));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = is_reg(a, `RTCU_OFS_CMD) | is_reg(a, `RTCU_OFS_REG0) | is_reg(a, `RTCU_OFS_TIME) |
             is_reg(a, `RTCU_OFS_ALARM) | is_reg(a, `RTCU_OFS_CONFIG) | is_reg(a, `RTCU_OFS_STATUS) |
             is_reg(a, `RTCU_OFS_IRQ_MASK);
  endfunction

  logic setup;
  logic wr_acc;
  logic cmd_wr;
  logic cmd_ok;
  logic [3:0] act;
  logic [3:0] opt;
  logic half_tick;
  logic sec_tick;
  logic alarm_hit;
  logic [31:0] half_limit;

  assign setup = ce & psel & ~penable;
  assign wr_acc = ce & psel & penable & pwrite & st.pready & ~st.pslverr;
  assign cmd_wr = wr_acc & is_reg(paddr, `RTCU_OFS_CMD);
  assign cmd_ok = cmd_wr & (pwdata[15:8] == `RTCU_OPCODE);
  assign act = pwdata[7:4];
  assign opt = pwdata[3:0];
  // Calibration stretches or shortens every second half-second period
  assign half_limit = HALF_LAST + ((st.cfg.cal_en & st.half) ? {{24{st.cfg.cal[7]}}, st.cfg.cal} : 32'h0);
  assign half_tick = ce & st.cfg.running & (st.presc >= half_limit);
  assign sec_tick = half_tick & st.half;
  assign alarm_hit = st.cfg.alarm_en & ((st.cfg.mask == 4'h0) ? half_tick :
                     (sec_tick & (st.now + 32'h1 >= st.next_alarm)));

  always_comb begin
    logic [`RTCU_ST_W-1:0] ev;
    logic [`RTCU_ST_W-1:0] clr;
    ev = '0;
    clr = '0;
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (setup) begin
      next_st.pready = 1'b1;
      next_st.pslverr = ~mapped(paddr);
      next_st.prdata = 32'h0;
      if (!pwrite) begin
        if (is_reg(paddr, `RTCU_OFS_REG0)) begin
          next_st.prdata = st.reg0;
        end else if (is_reg(paddr, `RTCU_OFS_TIME)) begin
          next_st.prdata = st.now;
        end else if (is_reg(paddr, `RTCU_OFS_ALARM)) begin
          next_st.prdata = st.alarm;
        end else if (is_reg(paddr, `RTCU_OFS_CONFIG)) begin
          next_st.prdata = {11'h0, st.cfg};
        end else if (is_reg(paddr, `RTCU_OFS_STATUS)) begin
          next_st.prdata = {29'h0, st.status};
        end else if (is_reg(paddr, `RTCU_OFS_IRQ_MASK)) begin
          next_st.prdata = {29'h0, st.irq_mask};
        end
      end
    end
    if (ce && st.cfg.running) begin
      next_st.presc = half_tick ? 32'h0 : st.presc + 32'h1;
      if (half_tick) begin
        next_st.half = ~st.half;
      end
      if (sec_tick) begin
        next_st.now = st.now + 32'h1;
      end
    end
    if (alarm_hit) begin
      ev[`RTCU_ST_ALARM] = 1'b1;
      if (!st.cfg.square) begin
        next_st.pin = ~st.pin;
      end
    end
    if (sec_tick && st.cfg.mask != 4'h0 && st.now + 32'h1 >= st.next_alarm) begin
      next_st.next_alarm = st.next_alarm + period_of(st.cfg.mask);
    end
    if (wr_acc && is_reg(paddr, `RTCU_OFS_REG0)) begin
      next_st.reg0 = pwdata;
    end
    if (wr_acc && is_reg(paddr, `RTCU_OFS_STATUS)) begin
      clr = pwdata[`RTCU_ST_W-1:0];
    end
    if (wr_acc && is_reg(paddr, `RTCU_OFS_IRQ_MASK)) begin
      next_st.irq_mask = pwdata[`RTCU_ST_W-1:0];
    end
    if (cmd_wr && !cmd_ok) begin
      ev[`RTCU_ST_REJECT] = 1'b1;
    end
    if (cmd_ok) begin
      next_st.cfg.last_action = act;
      case (act)
        `RTCU_ACT_INIT: begin
          next_st.cfg.pin_en = opt[`RTCU_OPT_PIN_EN];
          next_st.cfg.square = opt[`RTCU_OPT_SQUARE];
          next_st.cfg.cal_en = opt[`RTCU_OPT_CAL];
          next_st.cfg.cal = opt[`RTCU_OPT_CAL] ? st.reg0[`RTCU_CAL_W-1:0] : 8'h00;
          next_st.cfg.alarm_en = opt[`RTCU_OPT_ALARM_EN];
        end
        `RTCU_ACT_START: next_st.cfg.running = 1'b1;
        `RTCU_ACT_STOP: next_st.cfg.running = 1'b0;
        `RTCU_ACT_MASK: begin
          if (opt > `RTCU_MASK_MAX) begin
            ev[`RTCU_ST_REJECT] = 1'b1;
          end else begin
            next_st.cfg.mask = opt;
            next_st.next_alarm = st.alarm;
          end
        end
        `RTCU_ACT_WR_TIME: begin
          next_st.now = st.reg0;
          next_st.presc = 32'h0;
          next_st.half = 1'b0;
        end
        `RTCU_ACT_WR_ALARM: begin
          next_st.alarm = st.reg0;
          next_st.next_alarm = st.reg0;
        end
        `RTCU_ACT_RD_TIME: next_st.reg0 = st.now;
        `RTCU_ACT_RD_ALARM: next_st.reg0 = st.alarm;
        `RTCU_ACT_COUNT_TO_TEXT, `RTCU_ACT_TEXT_TO_COUNT,
        `RTCU_ACT_COUNT_TO_FIELDS, `RTCU_ACT_FIELDS_TO_COUNT: ev[`RTCU_ST_CONVERT] = 1'b1;
        default: ev[`RTCU_ST_REJECT] = 1'b1;
      endcase
    end
    // After the command, so a time write or a new mode shows on the pin at once
    if (next_st.cfg.square) begin
      next_st.pin = next_st.half;
    end
    // An event in the clearing cycle survives
    next_st.status = (st.status & ~clr) | ev;
    next_st.irq = |(next_st.status & next_st.irq_mask);
    next_st.pin_oe = next_st.cfg.pin_en;
    // Pin held low while disabled so it never floats inside the chip
    if (!next_st.cfg.pin_en) begin
      next_st.pin = 1'b0;
    end
    if (!ce) begin
      next_st = st;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign clock_event_pin = st.pin;
  assign clock_event_pin_oe = st.pin_oe;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  bad_opcode_a: assert property (cmd_wr && pwdata[15:8] != `RTCU_OPCODE |=> st.status[`RTCU_ST_REJECT] && $stable(st.cfg))
    else $error("foreign opcode not rejected");
  start_run_a: assert property (cmd_ok && act == `RTCU_ACT_START |=> st.cfg.running)
    else $error("start did not run clock");
  stop_run_a: assert property (cmd_ok && act == `RTCU_ACT_STOP |=> !st.cfg.running ##1 $stable(st.now))
    else $error("stop did not halt clock");
  read_time_a: assert property (cmd_ok && act == `RTCU_ACT_RD_TIME |=> st.reg0 == $past(st.now))
    else $error("read time wrong");
  convert_req_a: assert property (cmd_ok && act >= `RTCU_ACT_COUNT_TO_TEXT
    && act <= `RTCU_ACT_FIELDS_TO_COUNT |=> st.status[`RTCU_ST_CONVERT])
    else $error("conversion not requested");
  pin_enable_a: assert property (cmd_ok && act == `RTCU_ACT_INIT |=> ##1 clock_event_pin_oe == $past(opt[3], 2))
    else $error("pin enable mismatch");
  square_pin_a: assert property (st.cfg.square && half_tick |=> ##1 clock_event_pin == (st.half & st.pin_oe))
    else $error("square output wrong");
  cal_load_a: assert property (cmd_ok && act == `RTCU_ACT_INIT
    |=> st.cfg.cal == ($past(opt[1]) ? $past(st.reg0[7:0]) : 8'h00))
    else $error("calibration load wrong");
  alarm_flag_a: assert property (alarm_hit |=> st.status[`RTCU_ST_ALARM] ##1 st.irq == |(st.status & st.irq_mask))
    else $error("alarm flag or irq missing");
  alarm_off_a: assert property (!st.cfg.alarm_en && !st.cfg.square && !cmd_ok |=> $stable(st.pin))
    else $error("disabled alarm toggled pin");
  mask_load_a: assert property (cmd_ok && act == `RTCU_ACT_MASK && opt <= 4'h9 |=> st.cfg.mask == $past(opt))
    else $error("mask not loaded");
  sec_count_a: assert property (sec_tick && !cmd_wr |=> st.now == $past(st.now) + 32'h1)
    else $error("seconds count wrong");

  // Bus, freeze, interrupt, command, alarm, timekeeping and pin bookkeeping
  setup_ready_a: assert property (setup |=> st.pready)
    else $error("no ready after setup");
  ready_once_a: assert property (st.pready && ce |=> !st.pready)
    else $error("ready held too long");
  unmapped_err_a: assert property (setup && !mapped(paddr)
    |=> st.pslverr && st.prdata == 32'h0)
    else $error("unmapped access not flagged");
  unmapped_wr_a: assert property (ce && psel && penable && pwrite && st.pready && st.pslverr
    |=> $stable(st.reg0) && $stable(st.irq_mask))
    else $error("unmapped write took effect");
  freeze_hold_a: assert property (!ce |=> $stable(st))
    else $error("state moved while frozen");
  mask_write_a: assert property (wr_acc && is_reg(paddr, `RTCU_OFS_IRQ_MASK)
    |=> st.irq_mask == $past(pwdata[`RTCU_ST_W-1:0]))
    else $error("irq mask write lost");
  status_clear_a: assert property (wr_acc && is_reg(paddr, `RTCU_OFS_STATUS) && !alarm_hit
    |=> (st.status & $past(pwdata[`RTCU_ST_W-1:0])) == 3'h0)
    else $error("status bit not cleared");
  reg0_write_a: assert property (wr_acc && is_reg(paddr, `RTCU_OFS_REG0) |=> st.reg0 == $past(pwdata))
    else $error("register 0 write lost");
  irq_level_a: assert property (st.irq == |(st.status & st.irq_mask))
    else $error("irq out of step with status");
  write_time_a: assert property (cmd_ok && act == `RTCU_ACT_WR_TIME
    |=> st.now == $past(st.reg0) && st.presc == 32'h0 && !st.half)
    else $error("time write wrong");
  write_alarm_a: assert property (cmd_ok && act == `RTCU_ACT_WR_ALARM
    |=> st.alarm == $past(st.reg0) && st.next_alarm == $past(st.reg0))
    else $error("alarm write wrong");
  read_alarm_a: assert property (cmd_ok && act == `RTCU_ACT_RD_ALARM |=> st.reg0 == $past(st.alarm))
    else $error("read alarm wrong");
  bad_mask_a: assert property (cmd_ok && act == `RTCU_ACT_MASK && opt > `RTCU_MASK_MAX
    |=> st.status[`RTCU_ST_REJECT] && $stable(st.cfg.mask))
    else $error("out of range mask accepted");
  bad_action_a: assert property (cmd_ok && act > `RTCU_ACT_FIELDS_TO_COUNT
    |=> st.status[`RTCU_ST_REJECT] && st.cfg.running == $past(st.cfg.running))
    else $error("unknown action not rejected");
  alarm_gate_a: assert property (!st.cfg.alarm_en |=> !$rose(st.status[`RTCU_ST_ALARM]))
    else $error("alarm flag set while disabled");
  half_alarm_a: assert property (st.cfg.alarm_en && st.cfg.mask == 4'h0 && half_tick
    |=> st.status[`RTCU_ST_ALARM])
    else $error("half second alarm missing");
  period_step_a: assert property (st.cfg.alarm_en && st.cfg.mask != 4'h0 && sec_tick && !cmd_wr
    && st.now + 32'h1 >= st.next_alarm |=> st.status[`RTCU_ST_ALARM]
    && st.next_alarm == $past(st.next_alarm) + $past(period_of(st.cfg.mask)))
    else $error("repeat alarm wrong");
  half_only_a: assert property (half_tick && !st.half && !cmd_wr |=> st.now == $past(st.now))
    else $error("seconds moved on first half");
  stopped_hold_a: assert property (!st.cfg.running && !cmd_ok
    |=> $stable(st.now) && $stable(st.presc))
    else $error("stopped clock moved");
  pin_quiet_a: assert property (!st.pin_oe |-> !clock_event_pin)
    else $error("disabled pin driven");
endmodule
`default_nettype wire

// ===== verif/rtcu_host.sv
// Host model: issues register accesses and clock commands over APB
`timescale 1ns/1ps
`default_nettype none
module rtcu_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic last_err;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    last_err = 1'b0;
  end
  // Request held until pready is seen high; no fixed latency assumed
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  // Opcode byte always precedes the action byte
  task automatic cmd(input logic [7:0] action);
    wr(8'h00, {16'h0000, 8'hdc, action});
  endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the clock command unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int HALF = 300;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, pin, pin_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int n_errors = 0;
  int total_checks = 0;
  rtcu_top #(.ADDR_W(8), .HALF_CYCLES(HALF)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .clock_event_pin(pin), .clock_event_pin_oe(pin_oe));
  rtcu_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    i_host.rd(a, q);
    chk(q, exp);
  endtask
  task automatic results;
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_reject;
    i_host.wr(8'h00, 32'h0000_ab10);
    rchk(8'h14, 32'h0000_0002);
    rchk(8'h10, 32'h0000_0000);
    i_host.rd(8'h1c, q);
    chk({31'h0, i_host.last_err}, 32'h1);
    i_host.wr(8'h1c, 32'hffff_ffff);
    chk({31'h0, i_host.last_err}, 32'h1);
    i_host.wr(8'h14, 32'h0000_0007);
  endtask
  task automatic t_config;
    i_host.wr(8'h04, 32'h0000_005a);
    i_host.cmd(8'h0f);
    rchk(8'h10, 32'h000f_05a0);
    chk({31'h0, pin_oe}, 32'h1);
    i_host.cmd(8'h00);
    rchk(8'h10, 32'h0000_0000);
    chk({31'h0, pin_oe}, 32'h0);
  endtask
  task automatic t_actions;
    for (int a = 1; a < 12; a++) begin
      i_host.cmd({a[3:0], 4'h0});
      i_host.rd(8'h10, q);
      chk({28'h0, q[3:0]}, a);
      i_host.rd(8'h14, q);
      chk({31'h0, q[2]}, (a >= 8) ? 32'h1 : 32'h0);
    end
    i_host.wr(8'h14, 32'h0000_0007);
    i_host.cmd(8'hc0);
    rchk(8'h14, 32'h0000_0002);
    i_host.wr(8'h14, 32'h0000_0007);
  endtask
  task automatic t_time;
    i_host.wr(8'h04, 32'h0000_0064);
    i_host.cmd(8'h40);
    rchk(8'h08, 32'h0000_0064);
    i_host.cmd(8'h10);
    repeat (2 * HALF + 50) @(posedge pclk);
    rchk(8'h08, 32'h0000_0065);
    i_host.cmd(8'h20);
    repeat (3 * HALF) @(posedge pclk);
    rchk(8'h08, 32'h0000_0065);
    i_host.wr(8'h04, 32'h0000_0000);
    i_host.cmd(8'h60);
    rchk(8'h04, 32'h0000_0065);
  endtask
  task automatic t_alarm;
    logic p0;
    i_host.cmd(8'h09);
    i_host.cmd(8'h30);
    i_host.cmd(8'h10);
    i_host.wr(8'h18, 32'h0000_0001);
    repeat (HALF) @(posedge pclk);
    i_host.wr(8'h14, 32'h0000_0007);
    p0 = pin;
    repeat (HALF) @(posedge pclk);
    chk({31'h0, pin}, {31'h0, ~p0});
    rchk(8'h14, 32'h0000_0001);
    chk({31'h0, irq}, 32'h1);
    i_host.wr(8'h18, 32'h0000_0000);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    i_host.cmd(8'h3a);
    rchk(8'h14, 32'h0000_0003);
    i_host.cmd(8'h08);
    i_host.wr(8'h14, 32'h0000_0007);
    p0 = pin;
    repeat (2 * HALF) @(posedge pclk);
    rchk(8'h14, 32'h0000_0000);
    chk({31'h0, pin}, {31'h0, p0});
    i_host.cmd(8'h0c);
    repeat (HALF) @(posedge pclk);
    p0 = pin;
    repeat (HALF) @(posedge pclk);
    chk({31'h0, pin}, {31'h0, ~p0});
  endtask
  // Clock left running in square mode; a freeze must hold the pin and the seconds
  task automatic t_freeze;
    logic p0;
    i_host.wr(8'h04, 32'h0000_0200);
    i_host.cmd(8'h40);
    ce <= 1'b0;
    @(posedge pclk);
    p0 = pin;
    repeat (3 * HALF) @(posedge pclk);
    chk({31'h0, pin}, {31'h0, p0});
    ce <= 1'b1;
    rchk(8'h08, 32'h0000_0200);
  endtask
  // Alarm two seconds ahead with a one second repeat
  task automatic t_mask;
    i_host.wr(8'h04, 32'h0000_0300);
    i_host.cmd(8'h40);
    i_host.wr(8'h04, 32'h0000_0302);
    i_host.cmd(8'h50);
    i_host.cmd(8'h31);
    i_host.cmd(8'h01);
    i_host.wr(8'h14, 32'h0000_0007);
    repeat (HALF) @(posedge pclk);
    rchk(8'h14, 32'h0000_0000);
    repeat (2 * HALF) @(posedge pclk);
    rchk(8'h14, 32'h0000_0000);
    repeat (2 * HALF) @(posedge pclk);
    rchk(8'h14, 32'h0000_0001);
    rchk(8'h08, 32'h0000_0302);
    i_host.wr(8'h04, 32'h0000_0000);
    i_host.cmd(8'h70);
    rchk(8'h04, 32'h0000_0302);
  endtask
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({29'h0, irq, pin, pin_oe}, 32'h0);
    t_reject();
    t_config();
    t_actions();
    t_time();
    t_alarm();
    t_freeze();
    t_mask();
    results();
  end
  // Bench needs roughly 6k cycles; cut off well beyond
  initial begin
    #(8 * 40000);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
